// *** include/csf_pkg.sv ***
// Package for the condition and system flag logic
package csf_pkg;

   // Register bus address of the flag register
   localparam logic [7:0] ADDR_FLAGS = 8'h00;
   // Register bus address that nothing decodes; a read there returns RD_NONE
   localparam logic [7:0] ADDR_CTRL = 8'h01;

   // Bit positions in the flag register
   localparam int BIT_SIGNED_CMP = 7;
   localparam int BIT_CHAIN_ZERO = 6;
   localparam int BIT_EXPIRY = 5;
   localparam int BIT_PD = 4;
   localparam int BIT_WRAP = 3;
   localparam int BIT_Z = 2;
   localparam int BIT_HALF_CARRY = 1;
   localparam int BIT_C = 0;

   // Mask of bits that software and instructions may change
   localparam logic [7:0] WR_MASK = 8'hCF;
   // Reset value of the whole register
   localparam logic [7:0] FLAGS_RST = 8'h00;
   // Unmapped read answer
   localparam logic [7:0] RD_NONE = 8'h00;
   // Nibble carry position
   localparam int NIB = 4;

   // ALU operation classes
   typedef enum logic [2:0]
   {
      CSF_OP_NONE,
      CSF_OP_ADD,
      CSF_OP_SUB,
      CSF_OP_SBC,
      CSF_OP_LOGIC,
      CSF_OP_RLC,
      CSF_OP_RRC
   } csf_op_e;

   // One ALU update request
   typedef struct packed
   {
      logic valid;
      csf_op_e op;
      logic [7:0] a;
      logic [7:0] b;
   } csf_alu_s;

   // System events
   typedef struct packed
   {
      logic wdt_refresh;
      logic halt;
      logic wdt_timeout;
   } csf_sys_s;

endpackage : csf_pkg

// *** rtl/csf_flags.sv ***
// Condition and system flag register with bus access
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module csf_flags
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Register bus
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // ALU request
   input wire csf_pkg::csf_alu_s alu_in,
   // System events
   input wire csf_pkg::csf_sys_s sys_in,
   // Flag outputs and result
   output logic [7:0] flags,
   output logic [7:0] alu_result
);

   // ****************************************************
   // Flag computation
   // ****************************************************

   // Flag register, ALU result register (zero when no ALU request)
   logic [7:0] flags_r;
   logic [7:0] flags_nxt;
   logic [7:0] res_nxt;
   logic [7:0] res_r;

   // Add with carry in; returns {c8, c7, c4, sum}
   function automatic logic [10:0] add8(input logic [7:0] x,
                                         input logic [7:0] y,
                                         input logic ci);
      logic [4:0] lo;
      logic [3:0] mid;
      logic [1:0] hi;
      lo = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
      mid = {1'b0, x[6:4]} + {1'b0, y[6:4]} + {3'h0, lo[4]};
      hi = {1'b0, x[7]} + {1'b0, y[7]} + {1'b0, mid[3]};
      add8 = {hi[1], mid[3], lo[4], hi[0], mid[2:0], lo[3:0]};
   endfunction : add8

   // Next flags from the ALU and system events
   always_comb
   begin
      logic [10:0] s;
      logic carry;
      s = 11'h000;
      carry = flags_r[csf_pkg::BIT_C];
      flags_nxt = flags_r;
      res_nxt = 8'h00;
      // Software write to the flag register
      if (reg_wr && reg_addr == csf_pkg::ADDR_FLAGS)
      begin
         // Protected bits keep their value
         flags_nxt = (reg_wdata & csf_pkg::WR_MASK) |
                     (flags_r & ~csf_pkg::WR_MASK);
      end
      else if (alu_in.valid)
      begin
         unique case (alu_in.op)
            // Addition
            csf_pkg::CSF_OP_ADD:
            begin
               s = add8(alu_in.a, alu_in.b, 1'b0);
            end
            // Subtract: a + ~b + 1, carry means no borrow
            csf_pkg::CSF_OP_SUB:
            begin
               s = add8(alu_in.a, ~alu_in.b, 1'b1);
            end
            // Subtract with borrow: carry in is not-borrow
            csf_pkg::CSF_OP_SBC:
            begin
               s = add8(alu_in.a, ~alu_in.b, carry);
            end
            // Logic op result given in a
            csf_pkg::CSF_OP_LOGIC:
            begin
               s = {3'b000, alu_in.a};
            end
            // Rotate left through carry
            csf_pkg::CSF_OP_RLC:
            begin
               s = {3'b000, alu_in.a[6:0], carry};
            end
            // Rotate right through carry
            csf_pkg::CSF_OP_RRC:
            begin
               s = {3'b000, carry, alu_in.a[7:1]};
            end
            // No flag effect
            csf_pkg::CSF_OP_NONE:
            begin
               s = 11'h000;
            end
            default:
            begin
               s = 11'h000;
            end
         endcase
         res_nxt = s[7:0];
         unique case (alu_in.op)
            // Arithmetic group
            csf_pkg::CSF_OP_ADD, csf_pkg::CSF_OP_SUB,
            csf_pkg::CSF_OP_SBC:
            begin
               flags_nxt[csf_pkg::BIT_C] = s[10];
               flags_nxt[csf_pkg::BIT_HALF_CARRY] = s[8];
               flags_nxt[csf_pkg::BIT_Z] = (s[7:0] == 8'h00);
               flags_nxt[csf_pkg::BIT_WRAP] = s[10] ^ s[9];
               flags_nxt[csf_pkg::BIT_SIGNED_CMP] =
                  s[10] ^ s[9] ^ s[7];
               // Chained zero only for subtract groups
               if (alu_in.op == csf_pkg::CSF_OP_SUB)
                  flags_nxt[csf_pkg::BIT_CHAIN_ZERO] =
                     (s[7:0] == 8'h00);
               else if (alu_in.op == csf_pkg::CSF_OP_SBC)
                  flags_nxt[csf_pkg::BIT_CHAIN_ZERO] = (s[7:0] == 8'h00) &
                     flags_r[csf_pkg::BIT_CHAIN_ZERO];
            end
            // Logic ops touch zero only
            csf_pkg::CSF_OP_LOGIC:
            begin
               flags_nxt[csf_pkg::BIT_Z] = (s[7:0] == 8'h00);
            end
            // Rotates push the shifted-out bit into carry
            csf_pkg::CSF_OP_RLC:
            begin
               flags_nxt[csf_pkg::BIT_C] = alu_in.a[7];
            end
            csf_pkg::CSF_OP_RRC:
            begin
               flags_nxt[csf_pkg::BIT_C] = alu_in.a[0];
            end
            // Nothing changes
            csf_pkg::CSF_OP_NONE:
            begin
               flags_nxt = flags_r;
            end
            default:
            begin
               flags_nxt = flags_r;
            end
         endcase
      end
      // System flags: only these events move them
      if (sys_in.wdt_refresh)
      begin
         flags_nxt[csf_pkg::BIT_EXPIRY] = 1'b0;
         flags_nxt[csf_pkg::BIT_PD] = 1'b0;
      end
      else if (sys_in.halt)
      begin
         flags_nxt[csf_pkg::BIT_EXPIRY] = 1'b0;
         flags_nxt[csf_pkg::BIT_PD] = 1'b1;
      end
      // Timeout wins over a clear in the same cycle
      if (sys_in.wdt_timeout)
         flags_nxt[csf_pkg::BIT_EXPIRY] = 1'b1;
   end

   // ****************************************************
   // Registers
   // ****************************************************

   // Flag register; no stack save exists here
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         flags_r <= csf_pkg::FLAGS_RST;
      else
         flags_r <= flags_nxt;
   end

   // Result register
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         res_r <= 8'h00;
      else
         res_r <= res_nxt;
   end

   // Read data, valid one cycle after the read strobe
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         reg_rdata <= csf_pkg::RD_NONE;
      else if (reg_rd && reg_addr == csf_pkg::ADDR_FLAGS)
         reg_rdata <= flags_r;
      else
         reg_rdata <= csf_pkg::RD_NONE;
   end

   assign flags = flags_r;
   assign alu_result = res_r;

   // ****************************************************
   // Assertions
   // ****************************************************

   a_write_keeps_sys: assert property (@(posedge clk) disable iff (sys_rst)
      (reg_wr && reg_addr == csf_pkg::ADDR_FLAGS && !sys_in.wdt_refresh &&
       !sys_in.halt && !sys_in.wdt_timeout) |=>
      flags_r[csf_pkg::BIT_EXPIRY] == $past(flags_r[csf_pkg::BIT_EXPIRY]) &&
      flags_r[csf_pkg::BIT_PD] == $past(flags_r[csf_pkg::BIT_PD]))
      else $error("software write changed system flags");

   a_timeout_sets_to: assert property (@(posedge clk) disable iff (sys_rst)
      sys_in.wdt_timeout |=> flags_r[csf_pkg::BIT_EXPIRY])
      else $error("timeout did not set expiry flag");

   a_halt_sets_pd: assert property (@(posedge clk) disable iff (sys_rst)
      (sys_in.halt && !sys_in.wdt_refresh) |=>
      flags_r[csf_pkg::BIT_PD])
      else $error("halt did not set sleep flag");

   a_refresh_clears: assert property (@(posedge clk) disable iff (sys_rst)
      (sys_in.wdt_refresh && !sys_in.wdt_timeout) |=>
      !flags_r[csf_pkg::BIT_PD] && !flags_r[csf_pkg::BIT_EXPIRY])
      else $error("refresh did not clear system flags");

   a_add_carry: assert property (@(posedge clk) disable iff (sys_rst)
      (alu_in.valid && alu_in.op == csf_pkg::CSF_OP_ADD &&
       !(reg_wr && reg_addr == csf_pkg::ADDR_FLAGS)) |=>
      flags_r[csf_pkg::BIT_C] ==
      (({1'b0, $past(alu_in.a)} + {1'b0, $past(alu_in.b)}) > 9'h0FF))
      else $error("add carry wrong");

   a_zero_flag: assert property (@(posedge clk) disable iff (sys_rst)
      (alu_in.valid && alu_in.op == csf_pkg::CSF_OP_LOGIC &&
       !(reg_wr && reg_addr == csf_pkg::ADDR_FLAGS)) |=>
      flags_r[csf_pkg::BIT_Z] == ($past(alu_in.a) == 8'h00))
      else $error("zero flag wrong");

   a_signed_cmp_rel: assert property (@(posedge clk) disable iff (sys_rst)
      (alu_in.valid && alu_in.op == csf_pkg::CSF_OP_ADD &&
       !(reg_wr && reg_addr == csf_pkg::ADDR_FLAGS)) |=>
      flags_r[csf_pkg::BIT_SIGNED_CMP] ==
      (flags_r[csf_pkg::BIT_WRAP] ^ res_r[7]))
      else $error("sign compare flag wrong");

   a_chain_hold: assert property (@(posedge clk) disable iff (sys_rst)
      (alu_in.valid && alu_in.op == csf_pkg::CSF_OP_ADD &&
       !(reg_wr && reg_addr == csf_pkg::ADDR_FLAGS)) |=>
      $stable(flags_r[csf_pkg::BIT_CHAIN_ZERO]))
      else $error("chained zero changed by add");

   a_rlc_carry: assert property (@(posedge clk) disable iff (sys_rst)
      (alu_in.valid && alu_in.op == csf_pkg::CSF_OP_RLC &&
       !(reg_wr && reg_addr == csf_pkg::ADDR_FLAGS)) |=>
      flags_r[csf_pkg::BIT_C] == $past(alu_in.a[7]))
      else $error("rotate carry wrong");

   // Subtract carry means no borrow, so a is at least b
   a_sub_carry: assert property (@(posedge clk) disable iff (sys_rst)
      (alu_in.valid && alu_in.op == csf_pkg::CSF_OP_SUB &&
       !(reg_wr && reg_addr == csf_pkg::ADDR_FLAGS)) |=>
      flags_r[csf_pkg::BIT_C] == ($past(alu_in.a) >= $past(alu_in.b)))
      else $error("subtract carry wrong");

   // Half carry from the low nibble of an addition
   a_add_half: assert property (@(posedge clk) disable iff (sys_rst)
      (alu_in.valid && alu_in.op == csf_pkg::CSF_OP_ADD &&
       !(reg_wr && reg_addr == csf_pkg::ADDR_FLAGS)) |=>
      flags_r[csf_pkg::BIT_HALF_CARRY] == (({1'b0, $past(alu_in.a[3:0])} +
      {1'b0, $past(alu_in.b[3:0])}) > 5'h0F))
      else $error("half carry wrong");

   // Wrap on addition: like signs in, other sign out
   a_add_wrap: assert property (@(posedge clk) disable iff (sys_rst)
      (alu_in.valid && alu_in.op == csf_pkg::CSF_OP_ADD &&
       !(reg_wr && reg_addr == csf_pkg::ADDR_FLAGS)) |=>
      flags_r[csf_pkg::BIT_WRAP] == ($past(alu_in.a[7]) == $past(alu_in.b[7])
      && res_r[7] != $past(alu_in.a[7])))
      else $error("wrap flag wrong");

   // Halt clears expiry unless a timeout lands with it
   a_halt_clears_exp: assert property (@(posedge clk) disable iff (sys_rst)
      (sys_in.halt && !sys_in.wdt_timeout) |=>
      !flags_r[csf_pkg::BIT_EXPIRY])
      else $error("halt did not clear expiry flag");

   // Logic ops leave carry alone
   a_logic_keeps_c: assert property (@(posedge clk) disable iff (sys_rst)
      (alu_in.valid && alu_in.op == csf_pkg::CSF_OP_LOGIC &&
       !(reg_wr && reg_addr == csf_pkg::ADDR_FLAGS)) |=>
      $stable(flags_r[csf_pkg::BIT_C]))
      else $error("logic op changed carry");

   // Plain subtract copies zero into chained zero
   a_sub_chain: assert property (@(posedge clk) disable iff (sys_rst)
      (alu_in.valid && alu_in.op == csf_pkg::CSF_OP_SUB &&
       !(reg_wr && reg_addr == csf_pkg::ADDR_FLAGS)) |=>
      flags_r[csf_pkg::BIT_CHAIN_ZERO] == (res_r == 8'h00))
      else $error("chained zero wrong after subtract");

endmodule : csf_flags

`default_nettype wire

// *** sim/csf_exec_model.sv ***
// Execution unit model that issues ALU and system requests
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Requester on the execution side
// ****************************************
module csf_exec_model
(
   // Commands from the bench
   input wire logic go,
   input wire csf_pkg::csf_op_e op,
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire csf_pkg::csf_sys_s ev,
   // Requests to the flag block
   output csf_pkg::csf_alu_s alu_in,
   output csf_pkg::csf_sys_s sys_in
);
   // Idle operand lines show inverted data, never a stale copy
   always_comb
   begin
      alu_in.valid = go;
      alu_in.op = op;
      alu_in.a = go ? a : ~a;
      alu_in.b = go ? b : ~b;
      sys_in = ev;
   end
endmodule : csf_exec_model

`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the flag block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   // ****************************************
   // Signals and models
   // ****************************************
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic go = 1'b0;
   csf_pkg::csf_op_e op = csf_pkg::CSF_OP_NONE;
   logic [7:0] opa = 8'h00;
   logic [7:0] opb = 8'h00;
   csf_pkg::csf_sys_s ev = '0;
   csf_pkg::csf_alu_s alu_in;
   csf_pkg::csf_sys_s sys_in;
   logic [7:0] flags;
   logic [7:0] alu_result;
   logic [7:0] exp_f; // Expected flag register
   logic [31:0] rnd = 32'h318A; // Random state
   int errors = 0;
   int n_compared = 0;

   // Clock of 10 ns
   initial forever #5 clk = ~clk;

   csf_exec_model PART (.go, .op, .a(opa), .b(opb), .ev, .alu_in, .sys_in);
   csf_flags DUT (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .alu_in, .sys_in, .flags, .alu_result);

   // Next random state
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   // Expected result and flags of one ALU request
   function automatic logic [15:0] model(input csf_pkg::csf_op_e o,
      input logic [7:0] a, input logic [7:0] b, input logic [7:0] f);
      logic [7:0] bb;
      logic ci;
      logic [8:0] s;
      logic [7:0] n;
      bb = (o == csf_pkg::CSF_OP_ADD) ? b : ~b;
      ci = (o == csf_pkg::CSF_OP_SUB) | ((o == csf_pkg::CSF_OP_SBC) & f[0]);
      s = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
      n = f;
      if (o == csf_pkg::CSF_OP_LOGIC)
      begin
         s = {1'b0, a};
         n[2] = (a == 8'h00);
      end
      else if (o == csf_pkg::CSF_OP_RLC)
      begin
         s = {1'b0, a[6:0], f[0]};
         n[0] = a[7];
      end
      else if (o == csf_pkg::CSF_OP_RRC)
      begin
         s = {1'b0, f[0], a[7:1]};
         n[0] = a[0];
      end
      else
      begin
         n[0] = s[8];
         n[1] = ({1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci}) > 5'd15;
         n[2] = (s[7:0] == 8'h00);
         n[3] = (({1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h00, ci}) > 8'd127)
            ^ s[8];
         n[7] = n[3] ^ s[7];
         if (o == csf_pkg::CSF_OP_SUB) n[6] = n[2];
         if (o == csf_pkg::CSF_OP_SBC) n[6] = n[2] & f[6];
      end
      return {s[7:0], n};
   endfunction : model

   // ****************************************
   // Compare, bus and request tasks
   // ****************************************
   task automatic check(input string what, input logic [7:0] got,
      input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : check

   // One-cycle register write, then flag check
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= ad;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
      if (ad == 8'h00) exp_f = (d & 8'hCF) | (exp_f & 8'h30);
      check("write", flags, exp_f);
   endtask : wr

   // One-cycle register read, data checked in the next cycle
   task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= ad;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      check("read", reg_rdata, exp);
   endtask : rd

   // One ALU request, flags and result checked after it lands
   task automatic alu(input csf_pkg::csf_op_e o, input logic [7:0] a,
      input logic [7:0] b);
      logic [15:0] m;
      m = model(o, a, b, exp_f);
      @(posedge clk);
      go <= 1'b1;
      op <= o;
      opa <= a;
      opb <= b;
      @(posedge clk);
      go <= 1'b0;
      #1;
      exp_f = m[7:0];
      check("flags", flags, exp_f);
      check("result", alu_result, m[15:8]);
   endtask : alu

   // One system event pulse
   task automatic sys(input csf_pkg::csf_sys_s e);
      @(posedge clk);
      ev <= e;
      @(posedge clk);
      ev <= '0;
      #1;
      if (e.wdt_refresh | e.halt) exp_f[5] = 1'b0;
      if (e.wdt_timeout) exp_f[5] = 1'b1;
      if (e.halt) exp_f[4] = 1'b1;
      if (e.wdt_refresh) exp_f[4] = 1'b0;
      check("system", flags, exp_f);
   endtask : sys

   // Verdict and end of run
   task automatic finish_test();
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : finish_test

   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial
   begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      exp_f = 8'h00;
      #1;
      check("reset", flags, 8'h00);
      wr(8'h00, 8'hFF);
      rd(8'h00, 8'hCF);
      rd(8'h01, 8'h00);
      sys(3'b001);
      sys(3'b010);
      wr(8'h00, 8'h00);
      sys(3'b101);
      sys(3'b100);
      sys(3'b110);
      $display("register and system tests done");
      alu(csf_pkg::CSF_OP_ADD, 8'hFF, 8'h01);
      alu(csf_pkg::CSF_OP_ADD, 8'h7F, 8'h01);
      alu(csf_pkg::CSF_OP_SUB, 8'h05, 8'h05);
      alu(csf_pkg::CSF_OP_SBC, 8'h00, 8'h00);
      alu(csf_pkg::CSF_OP_SUB, 8'h80, 8'h01);
      alu(csf_pkg::CSF_OP_SUB, 8'h10, 8'h01);
      alu(csf_pkg::CSF_OP_RLC, 8'h80, 8'h00);
      alu(csf_pkg::CSF_OP_RRC, 8'h01, 8'h00);
      alu(csf_pkg::CSF_OP_LOGIC, 8'h00, 8'hFF);
      $display("corner ALU tests done");
      sys(3'b011);
      repeat (400)
      begin
         rnd = lfsr(rnd);
         if (rnd[10:8] == 3'h0)
            wr(rnd[7:0], rnd[23:16]);
         else
            alu(csf_pkg::csf_op_e'(3'd1 + 3'(rnd[7:0] % 8'd6)), rnd[15:8],
               rnd[23:16]);
      end
      $display("random tests done");
      @(posedge clk);
      sys_rst <= 1'b1;
      @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      check("rerun reset", flags, 8'h00);
      check("rerun result", alu_result, 8'h00);
      $display("reset test done");
      finish_test();
   end

   // Run is near 850 cycles; this limit is far beyond
   initial
   begin
      #200000;
      errors++;
      finish_test();
   end
endmodule : tb_top

`default_nettype wire
